//--- design/tap_consts.svh
// Constants of the boundary-scan test port
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

`define IR_W          3
`define IR_EXTEST     3'h0
`define IR_IDCODE     3'h1
`define IR_SAMPLEZ    3'h2
`define IR_SAMPLE     3'h4
`define IR_BYPASS     3'h7
`define IR_CAP_LOW    2'h1
`define IR_CAP_HIGH   1'h0
`define ID_W          32
// Identification value is arbitrary, bit 0 set as the scan standard asks
`define ID_VALUE      32'h0A5C_3001
`define BSR_W         8
`define BSR_OE_BIT    7
`define BSR_RESET     8'h80
`define BYPASS_CAP    1'h0
`define SYNC_N        4
`define SYNC_REQ      0
`define SYNC_UPD      1
`define SYNC_EXTEST   2
`define SYNC_SAMPLEZ  3

`endif

//--- design/tap_fsm.sv
// Sixteen-state test port controller steered by mode select
`timescale 1ns/1ps
module tap_fsm
  import tap_pkg::*;
(
  input  wire logic i_tck,
  input  wire logic i_rst_n,
  input  wire logic i_tms,
  tap_state_if.ctrl st
);
  tap_state_e state_q;
  tap_state_e state_d;

  // Five high mode-select edges reach reset from any state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET:    state_d = i_tms ? ST_RESET   : ST_IDLE;
      ST_IDLE:     state_d = i_tms ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_DR:   state_d = i_tms ? ST_SEL_IR  : ST_CAP_DR;
      ST_CAP_DR:   state_d = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = i_tms ? ST_UPD_DR  : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = i_tms ? ST_UPD_DR  : ST_SHIFT_DR;
      ST_UPD_DR:   state_d = i_tms ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_IR:   state_d = i_tms ? ST_RESET   : ST_CAP_IR;
      ST_CAP_IR:   state_d = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = i_tms ? ST_UPD_IR  : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = i_tms ? ST_UPD_IR  : ST_SHIFT_IR;
      ST_UPD_IR:   state_d = i_tms ? ST_SEL_DR  : ST_IDLE;
    endcase
  end

  // Mode select sampled on the rising test clock
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign st.state = state_q;
endmodule

//--- design/tap_pkg.sv
// Types of the boundary-scan test port
`include "tap_consts.svh"
package tap_pkg;
  typedef enum logic [3:0] {
    ST_RESET     = 4'h0,
    ST_IDLE      = 4'h1,
    ST_SEL_DR    = 4'h2,
    ST_CAP_DR    = 4'h3,
    ST_SHIFT_DR  = 4'h4,
    ST_EXIT1_DR  = 4'h5,
    ST_PAUSE_DR  = 4'h6,
    ST_EXIT2_DR  = 4'h7,
    ST_UPD_DR    = 4'h8,
    ST_SEL_IR    = 4'h9,
    ST_CAP_IR    = 4'hA,
    ST_SHIFT_IR  = 4'hB,
    ST_EXIT1_IR  = 4'hC,
    ST_PAUSE_IR  = 4'hD,
    ST_EXIT2_IR  = 4'hE,
    ST_UPD_IR    = 4'hF
  } tap_state_e;

  typedef logic [`BSR_W-1:0] bsr_t;
  typedef logic [`ID_W-1:0]  id_t;
  typedef logic [`IR_W-1:0]  ir_t;
endpackage

//--- design/tap_state_if.sv
// Controller state carried from the controller to the port core
`timescale 1ns/1ps
interface tap_state_if;
  import tap_pkg::*;
  tap_state_e state;
  modport ctrl (output state);
  modport core (input state);
endinterface

//--- design/tap_sync3.sv
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module tap_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule

//--- design/tap_top.sv
// Boundary-scan test access port with controller, instruction and data registers
//
// Behaviour
// - Port follows the standard boundary-scan controller and mandatory behaviour.
// - Test logic holds controller, instruction, boundary, bypass and identification registers.
// - Unconnected data-in and mode-select read as high through pull-ups.
// - Power-up puts test logic in reset without touching memory operation.
// - Inputs sampled on rising test clock; test clock drives only test logic.
// - Serial out and its enable change only on the falling test clock.
// - Far side steers the controller by mode select, sampled on rising edges.
// - Only the register chosen by the current instruction sits between in and out.
// - Serial input enters the most significant bit of the selected register.
// - Serial out shows the least significant bit, so data leaves LSB first.
// - Serial out driver on only in states that call for it.
// - Five rising edges with mode select high reset the test logic.
// - Three-bit instruction loads identification read at power-up and reset.
// - Instruction capture loads binary 01 into the two low bits.
// - One-bit bypass register between in and out, captured low.
`timescale 1ns/1ps
module tap_top
  import tap_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_tck,
  input  wire logic             i_tms,
  input  wire logic             i_tms_driven,
  input  wire logic             i_tdi,
  input  wire logic             i_tdi_driven,
  input  wire logic [`BSR_W-1:0] i_mem_pins,
  output logic                  o_tdo,
  output logic                  o_tdo_oe,
  output logic [`BSR_W-1:0]     o_bscan_drive,
  output logic                  o_extest,
  output logic                  o_out_bus_en
);
  tap_state_if st ();

  // Test clock reset release, asserted at once, released on test clock
  logic rs1_q;
  logic rs1_d;
  logic rs2_q;
  logic rs2_d;
  logic tck_rst_n;

  // Test clock domain state
  logic tms_in;
  logic tdi_in;
  ir_t  ir_shift_q;
  ir_t  ir_shift_d;
  ir_t  ir_q;
  ir_t  ir_d;
  logic bypass_q;
  logic bypass_d;
  id_t  id_q;
  id_t  id_d;
  bsr_t bsr_q;
  bsr_t bsr_d;
  bsr_t preload_q;
  bsr_t preload_d;
  logic req_t_q;
  logic req_t_d;
  logic upd_t_q;
  logic upd_t_d;
  logic extest_q;
  logic extest_d;
  logic samplez_q;
  logic samplez_d;
  logic sel_bsr;
  logic sel_id;
  logic tdo_q;
  logic tdo_d;
  logic tdo_oe_q;
  logic tdo_oe_d;

  // System clock domain state
  logic [`SYNC_N-1:0] sync_in;
  logic [`SYNC_N-1:0] sync_out;
  logic req_seen_q;
  logic req_seen_d;
  logic upd_seen_q;
  logic upd_seen_d;
  bsr_t held_q;
  bsr_t held_d;
  bsr_t drive_q;
  bsr_t drive_d;
  logic bus_en_q;
  logic bus_en_d;

  // Release moves one flop per rising test clock
  always_comb begin
    rs1_d = 1'b1;
    rs2_d = rs1_q;
  end

  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= rs1_d;
      rs2_q <= rs2_d;
    end
  end

  assign tck_rst_n = rs2_q;

  // Floating inputs read high
  assign tms_in = i_tms_driven ? i_tms : 1'b1;
  assign tdi_in = i_tdi_driven ? i_tdi : 1'b1;

  tap_fsm u_fsm (
    .i_tck   (i_tck),
    .i_rst_n (tck_rst_n),
    .i_tms   (tms_in),
    .st      (st.ctrl)
  );

  // Data register chosen by the held instruction
  always_comb begin
    sel_bsr = (ir_q == `IR_EXTEST) || (ir_q == `IR_SAMPLE) ||
              (ir_q == `IR_SAMPLEZ);
    sel_id  = (ir_q == `IR_IDCODE);
  end

  // Instruction path
  always_comb begin
    ir_shift_d = ir_shift_q;
    ir_d       = ir_q;
    unique case (st.state)
      ST_RESET: begin
        ir_d = `IR_IDCODE;
      end
      ST_CAP_IR: begin
        ir_shift_d = {`IR_CAP_HIGH, `IR_CAP_LOW};
      end
      ST_SHIFT_IR: begin
        ir_shift_d = {tdi_in, ir_shift_q[`IR_W-1:1]};
      end
      ST_UPD_IR: begin
        ir_d = ir_shift_q;
      end
      default: begin
        ir_shift_d = ir_shift_q;
      end
    endcase
  end

  // Data paths: bypass, identification and boundary registers
  always_comb begin
    bypass_d  = bypass_q;
    id_d      = id_q;
    bsr_d     = bsr_q;
    preload_d = preload_q;
    req_t_d   = req_t_q;
    upd_t_d   = upd_t_q;
    unique case (st.state)
      ST_RESET: begin
        // Boundary outputs preset again and handed over once
        if (preload_q != `BSR_RESET) begin
          preload_d = `BSR_RESET;
          upd_t_d   = ~upd_t_q;
        end
      end
      ST_SEL_DR: begin
        req_t_d = ~req_t_q;
      end
      ST_CAP_DR: begin
        bypass_d = `BYPASS_CAP;
        id_d     = `ID_VALUE;
        if (sel_bsr) begin
          bsr_d = held_q;
        end
      end
      ST_SHIFT_DR: begin
        if (sel_bsr) begin
          bsr_d = {tdi_in, bsr_q[`BSR_W-1:1]};
        end else if (sel_id) begin
          id_d = {tdi_in, id_q[`ID_W-1:1]};
        end else begin
          bypass_d = tdi_in;
        end
      end
      ST_UPD_DR: begin
        if (sel_bsr) begin
          preload_d = bsr_q;
          upd_t_d   = ~upd_t_q;
        end
      end
      default: begin
        bypass_d = bypass_q;
      end
    endcase
  end

  // Instruction modes that reach the memory side, moving with the instruction
  always_comb begin
    extest_d  = (ir_d == `IR_EXTEST);
    samplez_d = (ir_d == `IR_SAMPLEZ);
  end

  // All inputs taken on the rising test clock
  always_ff @(posedge i_tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_shift_q <= `IR_IDCODE;
      ir_q       <= `IR_IDCODE;
    end else begin
      ir_shift_q <= ir_shift_d;
      ir_q       <= ir_d;
    end
  end

  // Data registers and the toggles that announce capture and update
  always_ff @(posedge i_tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      bypass_q   <= `BYPASS_CAP;
      id_q       <= `ID_VALUE;
      bsr_q      <= `BSR_RESET;
      preload_q  <= `BSR_RESET;
      req_t_q    <= 1'b0;
      upd_t_q    <= 1'b0;
    end else begin
      bypass_q   <= bypass_d;
      id_q       <= id_d;
      bsr_q      <= bsr_d;
      preload_q  <= preload_d;
      req_t_q    <= req_t_d;
      upd_t_q    <= upd_t_d;
    end
  end

  // Mode levels from flops so the crossing sees no glitch
  always_ff @(posedge i_tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      extest_q   <= 1'b0;
      samplez_q  <= 1'b0;
    end else begin
      extest_q   <= extest_d;
      samplez_q  <= samplez_d;
    end
  end

  // Serial out from the low bit of the selected register
  always_comb begin
    tdo_oe_d = (st.state == ST_SHIFT_DR) || (st.state == ST_SHIFT_IR);
    if (st.state == ST_SHIFT_IR) begin
      tdo_d = ir_shift_q[0];
    end else if (sel_bsr) begin
      tdo_d = bsr_q[0];
    end else if (sel_id) begin
      tdo_d = id_q[0];
    end else begin
      tdo_d = bypass_q;
    end
  end

  // Outputs change on the falling test clock
  always_ff @(negedge i_tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign o_tdo    = tdo_q;
  assign o_tdo_oe = tdo_oe_q;

  // Crossing of toggles and mode levels into the system clock
  assign sync_in[`SYNC_REQ]     = req_t_q;
  assign sync_in[`SYNC_UPD]     = upd_t_q;
  assign sync_in[`SYNC_EXTEST]  = extest_q;
  assign sync_in[`SYNC_SAMPLEZ] = samplez_q;

  genvar g;
  generate
    for (g = 0; g < `SYNC_N; g++) begin : g_sync
      tap_sync3 u_sync (
        .i_clk   (i_clk_sys),
        .i_rst_n (i_rst_n),
        .i_async (sync_in[g]),
        .o_level (sync_out[g])
      );
    end
  endgenerate

  // Words cross by toggle alone
  // Slow test clock keeps each word steady before it is read
  // Pin snapshot held steady for capture; preload copied after update
  always_comb begin
    req_seen_d = sync_out[`SYNC_REQ];
    upd_seen_d = sync_out[`SYNC_UPD];
    held_d     = held_q;
    drive_d    = drive_q;
    if (sync_out[`SYNC_REQ] != req_seen_q) begin
      held_d = i_mem_pins;
    end
    if (sync_out[`SYNC_UPD] != upd_seen_q) begin
      drive_d = preload_q;
    end
  end

  // Memory output bus untouched outside test instructions
  always_comb begin
    if (sync_out[`SYNC_SAMPLEZ]) begin
      bus_en_d = 1'b0;
    end else if (sync_out[`SYNC_EXTEST]) begin
      bus_en_d = drive_q[`BSR_OE_BIT];
    end else begin
      bus_en_d = 1'b1;
    end
  end

  // Snapshot and boundary output words in the system clock
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_seen_q <= 1'b0;
      upd_seen_q <= 1'b0;
      held_q     <= '0;
      drive_q    <= `BSR_RESET;
    end else begin
      req_seen_q <= req_seen_d;
      upd_seen_q <= upd_seen_d;
      held_q     <= held_d;
      drive_q    <= drive_d;
    end
  end

  // Memory output bus enable register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_en_q   <= 1'b1;
    end else begin
      bus_en_q   <= bus_en_d;
    end
  end

  assign o_bscan_drive = drive_q;
  assign o_extest      = sync_out[`SYNC_EXTEST];
  assign o_out_bus_en  = bus_en_q;
endmodule

//--- verification/tap_checker_props.sv
// Checker of the test port outputs
`timescale 1ns/1ps
`include "tap_consts.svh"
module tap_checker (
  input wire logic              i_clk_sys,
  input wire logic              i_rst_n,
  input wire logic              i_tck,
  input wire logic              i_tms,
  input wire logic              i_tms_driven,
  input wire logic              o_tdo,
  input wire logic              o_tdo_oe,
  input wire logic [`BSR_W-1:0] o_bscan_drive,
  input wire logic              o_extest,
  input wire logic              o_out_bus_en
);
  logic       tms_eff;
  logic [2:0] ones_d;
  logic [2:0] ones_q;
  // Run of mode-select-high edges, pull-up included
  always_comb begin
    tms_eff = i_tms | ~i_tms_driven;
    ones_d = !tms_eff ? 3'h0 : (ones_q == 3'h7) ? ones_q : ones_q + 3'h1;
  end
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) ones_q <= 3'h0;
    else ones_q <= ones_d;
  end

  tdo_on_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $changed(o_tdo) |-> !i_tck) else $error("Serial out moved with clock high");
  oe_on_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $changed(o_tdo_oe) |-> !i_tck) else $error("Enable moved with clock high");
  shift_only_a: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    $past(tms_eff) |-> !o_tdo_oe) else $error("Driver on outside shift");
  oe_entry_a: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    $rose(o_tdo_oe) |-> !$past(tms_eff) && (!$past(tms_eff, 2) || !$past(tms_eff, 3)))
    else $error("Driver on without capture and shift");
  tlr_clears_a: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    ones_q == 3'h5 |-> ##1 (!o_extest && o_out_bus_en)) else $error("Reset left test mode");
  rst_values_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> o_bscan_drive == `BSR_RESET && !o_tdo_oe && !o_extest
    && o_out_bus_en) else $error("Bad values after reset");
  extest_bus_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_extest && $past(o_extest, 2) && $past(o_bscan_drive, 2) == o_bscan_drive
    |-> o_out_bus_en == o_bscan_drive[`BSR_OE_BIT]) else $error("Bus enable wrong");
  extest_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $changed(o_extest) |-> !o_tdo_oe) else $error("Mode moved during shift");
endmodule

//--- verification/tap_host.sv
// Board-level test controller model driving the scan port
`timescale 1ns/1ps
module tap_host (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tms_driven,
  output logic      o_tdi,
  output logic      o_tdi_driven,
  input  wire logic i_tdo  // Only read, never driven
);
  // Clock parked low and pins floating at start; between frames data-in floats but mode select stays driven
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b0;
    o_tms_driven = 1'b0;
    o_tdi = 1'b0;
    o_tdi_driven = 1'b0;
  end

  // One test clock period; serial out taken just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #32;
    tdo = i_tdo;
    o_tck = 1'b1;
    #32;
    o_tck = 1'b0;
  endtask

  // Mode select left floating so the pull-up holds it high
  task automatic reset(input int n);
    logic t;
    o_tms_driven = 1'b0;
    repeat (n) tick(1'b0, 1'b0, t);
    o_tms_driven = 1'b1;
    tick(1'b0, 1'b0, t);
  endtask

  // From idle through capture and shift back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = 32'h0;
    o_tms_driven = 1'b1;
    o_tdi_driven = 1'b1;
    tick(1'b1, 1'b0, t);
    if (ir) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    tick(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    o_tdi_driven = 1'b0;
  endtask
endmodule

//--- verification/tb_tap_top.sv
// Testbench of the boundary-scan test port
`timescale 1ns/1ps
`include "tap_consts.svh"
module tb_tap_top;
  import tap_pkg::*;
  logic        i_clk_sys;
  logic        i_rst_n;
  logic        tck, tms, tms_drv, tdi, tdi_drv;
  logic [7:0]  i_mem_pins;
  logic        o_tdo, o_tdo_oe, o_extest, o_out_bus_en;
  bsr_t        o_bscan_drive;
  logic [31:0] seed;
  logic [31:0] d;
  logic [31:0] r;
  int          num_errors;
  int          num_checks;
  // Bypass code and the three reserved codes, three bits each
  localparam logic [11:0] bypass_codes = 12'hEEE;

  tap_top u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms),
    .i_tms_driven(tms_drv), .i_tdi(tdi), .i_tdi_driven(tdi_drv), .i_mem_pins(i_mem_pins),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_bscan_drive(o_bscan_drive),
    .o_extest(o_extest), .o_out_bus_en(o_out_bus_en));
  tap_host u_host (.o_tck(tck), .o_tms(tms), .o_tms_driven(tms_drv), .o_tdi(tdi),
    .o_tdi_driven(tdi_drv), .i_tdo(o_tdo));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Load an instruction, then let the system side settle
  task automatic load_ir(input logic [2:0] code);
    u_host.scan(1'b1, 3, 32'(code), d);
    check(d, 32'h1);
    repeat (20) @(posedge i_clk_sys);
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    seed = 32'h0000_7299;
    num_errors = 0;
    num_checks = 0;
    i_rst_n <= 1'b0;
    i_mem_pins <= 8'h00;
    repeat (6) @(posedge i_clk_sys);
    check(32'(o_bscan_drive), 32'(`BSR_RESET));
    check(32'({o_tdo_oe, o_extest, o_out_bus_en}), 32'h1);
    i_rst_n <= 1'b1;
    u_host.reset(7);
    u_host.scan(1'b0, 32, rnd(), d);
    check(d, `ID_VALUE);
    for (int k = 0; k < 4; k++) begin
      load_ir(bypass_codes[3*k+:3]);
      r = rnd();
      u_host.scan(1'b0, 32, r, d);
      check(d, {r[30:0], 1'b0});
    end
    r = rnd();
    @(posedge i_clk_sys);
    i_mem_pins <= r[15:8];
    load_ir(3'h4);
    u_host.scan(1'b0, 8, r, d);
    check(d, 32'(r[15:8]));
    repeat (20) @(posedge i_clk_sys);
    check(32'(o_bscan_drive), 32'(r[7:0]));
    load_ir(3'h2);
    check(32'({o_extest, o_out_bus_en}), 32'h0);
    load_ir(3'h0);
    check(32'({o_extest, o_out_bus_en}), 32'({1'b1, r[7]}));
    u_host.scan(1'b0, 8, ~r, d);
    check(d, 32'(r[15:8]));
    repeat (20) @(posedge i_clk_sys);
    check(32'(o_out_bus_en), {31'h0, ~r[7]});
    u_host.reset(5);
    repeat (20) @(posedge i_clk_sys);
    check(32'({o_extest, o_out_bus_en}), 32'h1);
    check(32'(o_bscan_drive), 32'(`BSR_RESET));
    u_host.scan(1'b0, 32, rnd(), d);
    check(d, `ID_VALUE);
    print_verdict();
  end
endmodule

bind tap_top tap_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_tck(i_tck),
  .i_tms(i_tms), .i_tms_driven(i_tms_driven), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .o_bscan_drive(o_bscan_drive), .o_extest(o_extest), .o_out_bus_en(o_out_bus_en));
